// *** verilog/rtc_pkg.sv ***
/*
 * Shared constants for the real-time clock core: byte map, control bit
 * positions, oscillator and update timing.
 * Assumes a single 250 MHz core clock from which the 32.768 kHz time base
 * is synthesised by a phase accumulator.
 */
package rtc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock rates and divider
  localparam int          CLK_HZ         = 250_000_000;
  localparam int          OSC_HZ         = 32_768;
  localparam int          DIV_W          = 15;
  localparam logic [14:0] DIV_LAST       = 15'h7FFF;
  localparam logic [14:0] DIV_HALF       = 15'h4000;   // restart point: first update 500 ms later
  // lead of the update-pending bit before the update cycle
  localparam int          UPD_LEAD_US    = 244;
  localparam int          UPD_LEAD_TICKS = (UPD_LEAD_US * OSC_HZ + 999_999) / 1_000_000;
  localparam logic [14:0] DIV_PEND       = 15'(32_768 - UPD_LEAD_TICKS);

  ////////////////////////////////////////////////////////////////////////
  // byte map
  localparam logic [7:0] ADDR_SEC    = 8'h00;
  localparam logic [7:0] ADDR_AL_SEC = 8'h01;
  localparam logic [7:0] ADDR_MIN    = 8'h02;
  localparam logic [7:0] ADDR_AL_MIN = 8'h03;
  localparam logic [7:0] ADDR_HOUR   = 8'h04;
  localparam logic [7:0] ADDR_AL_HR  = 8'h05;
  localparam logic [7:0] ADDR_WDAY   = 8'h06;
  localparam logic [7:0] ADDR_MDAY   = 8'h07;
  localparam logic [7:0] ADDR_MONTH  = 8'h08;
  localparam logic [7:0] ADDR_YEAR   = 8'h09;
  localparam logic [7:0] ADDR_CTRL_A = 8'h0A;
  localparam logic [7:0] ADDR_CTRL_B = 8'h0B;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
  localparam int         NUM_TIME    = 10;

  ////////////////////////////////////////////////////////////////////////
  // control A / B / flag bit positions
  localparam int         A_PEND      = 7;
  localparam int         B_FREEZE    = 7;
  localparam int         B_PER_EN    = 6;
  localparam int         B_AL_EN     = 5;
  localparam int         B_UPD_EN    = 4;
  localparam int         B_WAVE_EN   = 3;
  localparam int         B_FMT       = 2;
  localparam int         B_H24       = 1;
  localparam int         B_SEASON    = 0;
  localparam int         F_IRQ       = 7;
  localparam int         F_PER       = 6;
  localparam int         F_AL        = 5;
  localparam int         F_UPD       = 4;
  localparam logic [2:0] OSC_RUN     = 3'b010;
  localparam logic [1:0] OSC_HOLD    = 2'b11;
  localparam logic [1:0] DONT_CARE   = 2'b11;

  ////////////////////////////////////////////////////////////////////////
  // reset values of the counting copy (binary)
  localparam logic [5:0] RST_SEC     = 6'h00;
  localparam logic [4:0] RST_HOUR    = 5'h00;
  localparam logic [2:0] RST_WDAY    = 3'h1;
  localparam logic [4:0] RST_MDAY    = 5'h01;
  localparam logic [3:0] RST_MONTH   = 4'h1;
  localparam logic [6:0] RST_YEAR    = 7'h00;

endpackage

// *** verilog/rtc_core.sv ***
/*
 * Timekeeping core of a real-time clock: seconds-to-year counting in BCD or
 * binary, 12/24-hour modes, host buffer with transfer freeze, alarm,
 * periodic and update-ended events, square-wave output, open-drain
 * interrupt, and the multiplexed address/data host port (write/read strobes).
 * Assumes all host pins are asynchronous to ref_clk and that host strobes
 * last many ref_clk periods; the time base is synthesised from ref_clk.
 */
`timescale 1ns/10ps

// Notes on behaviour
// [RL1] count time once every second
// [RL2] freeze keeps host copy, counting continues
// [RL3] pending bit rises shortly before update
// [RL4] update end clears pending, sets done flag
// [RL5] format bit selects BCD or binary
// [RL6] hour bit selects 12 or 24 hours
// [RL7] ten time bytes at addresses zero..nine
// [RL8] twelve-hour mode: bit seven marks PM
// [RL9] host freezes, writes bytes, then releases
// [RL10] divide time base, mux thirteen taps
// [RL11] square wave runs only when enabled
// [RL12] rate field maps to tap frequencies
// [RL13] periodic event uses same rate field
// [RL14] flags set always, requests need enable
// [RL15] summary flag set on every request
// [RL16] flag read clears flags, releases pin
// [RL17] update compares time against alarm bytes
// [RL18] both top bits set mean don't care
// [RL19] update request needs enable, no freeze
// [RL20] interrupt pin open drain, low when pending
// [RL21] square wave low when disabled
// [RL22] oscillator field runs or holds divider
// [RL23] pending reads zero while frozen
// [RL24] frozen time writes load counting copy
// [RL25] reads return the host buffer copy
module rtc_core (
  input  wire logic       ref_clk,       // 250 MHz core clock
  input  wire logic       nrst,          // async reset, active low
  input  wire logic [7:0] ad_in,         // address/data pins, input side
  output logic      [7:0] ad_out,        // address/data pins, output side
  output logic            ad_oe,         // address/data drive enable
  input  wire logic       addr_strobe,   // address latch, falling edge
  input  wire logic       rd_strobe_n,   // read strobe, active low
  input  wire logic       wr_strobe_n,   // write strobe, data taken on rise
  input  wire logic       chip_sel_n,    // chip select, active low
  output logic            irq_pin_out,   // open-drain interrupt level (always 0)
  output logic            irq_pin_oe,    // pulls the interrupt pin low
  output logic            wave_out       // square-wave output
);

  ////////////////////////////////////////////////////////////////////////
  // helper functions
  function automatic logic [7:0] to_ext(input logic [6:0] v, input logic bin);
    to_ext = bin ? {1'b0, v} : {4'(v / 7'd10), 4'(v % 7'd10)};  // [RL5]
  endfunction

  function automatic logic [6:0] to_int(input logic [7:0] e, input logic bin);
    to_int = bin ? e[6:0] : 7'(7'(e[7:4]) * 7'd10 + 7'(e[3:0]));  // [RL5]
  endfunction

  function automatic logic [7:0] hour_ext(input logic [4:0] h, input logic bin,
                                          input logic h24);
    logic [4:0] h12;
    logic [7:0] e12;
    h12 = (h >= 5'd12) ? 5'(h - 5'd12) : h;
    if (h12 == 5'd0) h12 = 5'd12;
    e12 = to_ext({2'b00, h12}, bin);
    if (h24) hour_ext = to_ext({2'b00, h}, bin);                        // [RL6]
    else     hour_ext = {h >= 5'd12, e12[6:0]};                          // [RL8]
  endfunction

  function automatic logic [4:0] hour_int(input logic [7:0] e, input logic bin,
                                          input logic h24);
    logic [4:0] h;
    h = 5'(to_int({1'b0, e[6:0]}, bin));
    if (!h24) begin
      if (h == 5'd12) h = 5'd0;
      if (e[7]) h = 5'(h + 5'd12);   // [RL8]
    end
    hour_int = h;
  endfunction

  function automatic logic [4:0] month_len(input logic [3:0] m, input logic [6:0] y);
    case (m)
      4'h2:                      month_len = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB:    month_len = 5'd30;
      default:                   month_len = 5'd31;
    endcase
  endfunction

  // rate field to divider bit; the bit toggles at 32768/2^(k+1) Hz
  function automatic logic [3:0] tap_sel(input logic [3:0] rs);
    case (rs)
      4'h1:    tap_sel = 4'h6;
      4'h2:    tap_sel = 4'h7;
      default: tap_sel = 4'(rs - 4'h2);
    endcase
  endfunction

  function automatic logic al_match(input logic [7:0] al, input logic [7:0] cur);
    al_match = (al[7:6] == rtc_pkg::DONT_CARE) || (al == cur);   // [RL18]
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [11:0] pins_s1_q, pins_s2_q, pins_s3_q;   // {cs_n, wr_n, rd_n, as, ad}
  logic [7:0]  addr_q;
  logic [7:0]  buf_q [rtc_pkg::NUM_TIME];         // host-visible copy and alarms
  logic [5:0]  sec_q, min_q;
  logic [4:0]  hour_q, mday_q;
  logic [2:0]  wday_q;
  logic [3:0]  month_q;
  logic [6:0]  year_q;
  logic [2:0]  osc_ctrl_q;
  logic [3:0]  rate_select_q;
  logic        transfer_freeze_q, periodic_irq_en_q, alarm_irq_en_q, update_irq_en_q;
  logic        wave_out_en_q, data_format_sel_q, hour_format_sel_q, season_adj_en_q;
  logic [27:0] acc_q;
  logic        osc_tick_q;
  logic [14:0] div_q;
  logic        upd_end_q, update_pending_q, tap_q;
  logic        periodic_flag_q, alarm_flag_q, update_done_flag_q, irq_summary_flag_q;
  logic [7:0]  ad_out_q;
  logic        ad_oe_q, irq_pin_oe_q, wave_out_q;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only stage two and three feed logic
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_s1_q <= 12'hE00;
      pins_s2_q <= 12'hE00;
      pins_s3_q <= 12'hE00;
    end else begin
      pins_s1_q <= {chip_sel_n, wr_strobe_n, rd_strobe_n, addr_strobe, ad_in};
      pins_s2_q <= pins_s1_q;
      pins_s3_q <= pins_s2_q;
    end
  end

  // strobe edges, seen two cycles after the pins move
  logic addr_fall, wr_done, rd_active, rd_done, fmt_bin, h24, running, upd_tick;
  logic [7:0] wr_data;
  assign addr_fall = pins_s3_q[8] & ~pins_s2_q[8];
  assign wr_done   = ~pins_s3_q[10] & pins_s2_q[10] & ~pins_s3_q[11];
  assign rd_done   = ~pins_s3_q[9] & pins_s2_q[9] & ~pins_s3_q[11];
  assign rd_active = ~pins_s2_q[9] & ~pins_s2_q[11];
  assign wr_data   = pins_s3_q[7:0];
  assign fmt_bin   = data_format_sel_q;
  assign h24       = hour_format_sel_q;

  // address latch, independent of chip select
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) addr_q <= 8'h00;
    else if (addr_fall) addr_q <= pins_s2_q[7:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // time base: phase accumulator makes the 32.768 kHz tick
  logic osc_on, div_hold;
  logic [28:0] acc_sum;
  assign osc_on   = (osc_ctrl_q == rtc_pkg::OSC_RUN) || (osc_ctrl_q[2:1] == rtc_pkg::OSC_HOLD);
  assign div_hold = (osc_ctrl_q[2:1] == rtc_pkg::OSC_HOLD);
  assign running  = (osc_ctrl_q == rtc_pkg::OSC_RUN);
  assign acc_sum  = 29'(acc_q) + 29'(rtc_pkg::OSC_HZ);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_q      <= 28'h0000000;
      osc_tick_q <= 1'b0;
    end else if (!osc_on) begin
      osc_tick_q <= 1'b0;   // oscillator stopped: no ticks
    end else if (acc_sum >= 29'(rtc_pkg::CLK_HZ)) begin
      acc_q      <= 28'(acc_sum - 29'(rtc_pkg::CLK_HZ));
      osc_tick_q <= 1'b1;
    end else begin
      acc_q      <= 28'(acc_sum);
      osc_tick_q <= 1'b0;
    end
  end

  // divider chain; held at half so release gives the first update in 500 ms
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) div_q <= rtc_pkg::DIV_HALF;
    else if (div_hold) div_q <= rtc_pkg::DIV_HALF;          // [RL22]
    else if (running && osc_tick_q) div_q <= 15'(div_q + 15'd1);   // [RL10]
  end

  assign upd_tick = running & osc_tick_q & (div_q == rtc_pkg::DIV_LAST);   // [RL1]

  ////////////////////////////////////////////////////////////////////////
  // update pending and update-end strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      update_pending_q <= 1'b0;
      upd_end_q        <= 1'b0;
    end else begin
      upd_end_q <= upd_tick;
      if (upd_end_q) update_pending_q <= 1'b0;                          // [RL4]
      else if (running && div_q >= rtc_pkg::DIV_PEND) update_pending_q <= 1'b1;   // [RL3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counting copy, binary; host writes override the tick
  logic [7:0] wr_addr;
  assign wr_addr = addr_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sec_q   <= rtc_pkg::RST_SEC;
      min_q   <= rtc_pkg::RST_SEC;
      hour_q  <= rtc_pkg::RST_HOUR;
      wday_q  <= rtc_pkg::RST_WDAY;
      mday_q  <= rtc_pkg::RST_MDAY;
      month_q <= rtc_pkg::RST_MONTH;
      year_q  <= rtc_pkg::RST_YEAR;
    end else if (wr_done) begin
      // frozen or not, written time lands in the counting copy too
      case (wr_addr)   // [RL24]
        rtc_pkg::ADDR_SEC:   sec_q   <= 6'(to_int(wr_data, fmt_bin));
        rtc_pkg::ADDR_MIN:   min_q   <= 6'(to_int(wr_data, fmt_bin));
        rtc_pkg::ADDR_HOUR:  hour_q  <= hour_int(wr_data, fmt_bin, h24);
        rtc_pkg::ADDR_WDAY:  wday_q  <= 3'(to_int(wr_data, fmt_bin));
        rtc_pkg::ADDR_MDAY:  mday_q  <= 5'(to_int(wr_data, fmt_bin));
        rtc_pkg::ADDR_MONTH: month_q <= 4'(to_int(wr_data, fmt_bin));
        rtc_pkg::ADDR_YEAR:  year_q  <= to_int(wr_data, fmt_bin);
        default: ;
      endcase
    end else if (upd_tick) begin   // [RL1] [RL2]
      sec_q <= (sec_q == 6'd59) ? 6'd0 : 6'(sec_q + 6'd1);
      if (sec_q == 6'd59) begin
        min_q <= (min_q == 6'd59) ? 6'd0 : 6'(min_q + 6'd1);
        if (min_q == 6'd59) begin
          hour_q <= (hour_q == 5'd23) ? 5'd0 : 5'(hour_q + 5'd1);   // [RL6]
          if (hour_q == 5'd23) begin
            wday_q <= (wday_q == 3'd7) ? 3'd1 : 3'(wday_q + 3'd1);  // [RL7]
            if (mday_q >= month_len(month_q, year_q)) begin
              mday_q  <= 5'd1;
              month_q <= (month_q == 4'd12) ? 4'd1 : 4'(month_q + 4'd1);
              if (month_q == 4'd12) year_q <= (year_q == 7'd99) ? 7'd0 : 7'(year_q + 7'd1);
            end else begin
              mday_q <= 5'(mday_q + 5'd1);
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host buffer: alarm bytes live here only; time bytes refreshed at update end unless frozen
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < rtc_pkg::NUM_TIME; i++) buf_q[i] <= 8'h00;
    end else if (wr_done && wr_addr < 8'(rtc_pkg::NUM_TIME)) begin
      buf_q[wr_addr[3:0]] <= wr_data;   // [RL7] [RL9]
    end else if (upd_end_q && !transfer_freeze_q) begin   // [RL2] [RL25]
      buf_q[rtc_pkg::ADDR_SEC[3:0]]   <= to_ext({1'b0, sec_q}, fmt_bin);
      buf_q[rtc_pkg::ADDR_MIN[3:0]]   <= to_ext({1'b0, min_q}, fmt_bin);
      buf_q[rtc_pkg::ADDR_HOUR[3:0]]  <= hour_ext(hour_q, fmt_bin, h24);
      buf_q[rtc_pkg::ADDR_WDAY[3:0]]  <= to_ext({4'h0, wday_q}, fmt_bin);
      buf_q[rtc_pkg::ADDR_MDAY[3:0]]  <= to_ext({2'b00, mday_q}, fmt_bin);
      buf_q[rtc_pkg::ADDR_MONTH[3:0]] <= to_ext({3'b000, month_q}, fmt_bin);
      buf_q[rtc_pkg::ADDR_YEAR[3:0]]  <= to_ext(year_q, fmt_bin);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control A and B; pending bit of A is read-only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_ctrl_q        <= 3'h0;
      rate_select_q     <= 4'h0;
      transfer_freeze_q <= 1'b0;
      periodic_irq_en_q <= 1'b0;
      alarm_irq_en_q    <= 1'b0;
      update_irq_en_q   <= 1'b0;
      wave_out_en_q     <= 1'b0;
      data_format_sel_q <= 1'b0;
      hour_format_sel_q <= 1'b0;
      season_adj_en_q   <= 1'b0;
    end else if (wr_done && wr_addr == rtc_pkg::ADDR_CTRL_A) begin
      osc_ctrl_q    <= wr_data[6:4];   // [RL22]
      rate_select_q <= wr_data[3:0];   // [RL12]
    end else if (wr_done && wr_addr == rtc_pkg::ADDR_CTRL_B) begin
      transfer_freeze_q <= wr_data[rtc_pkg::B_FREEZE];
      periodic_irq_en_q <= wr_data[rtc_pkg::B_PER_EN];
      alarm_irq_en_q    <= wr_data[rtc_pkg::B_AL_EN];
      update_irq_en_q   <= wr_data[rtc_pkg::B_UPD_EN];
      wave_out_en_q     <= wr_data[rtc_pkg::B_WAVE_EN];
      data_format_sel_q <= wr_data[rtc_pkg::B_FMT];   // [RL5]
      hour_format_sel_q <= wr_data[rtc_pkg::B_H24];   // [RL6]
      season_adj_en_q   <= wr_data[rtc_pkg::B_SEASON];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rate mux: square wave and periodic event share the tap
  logic tap_now, per_set;
  assign tap_now = running & (rate_select_q != 4'h0) & div_q[tap_sel(rate_select_q)];  // [RL12]
  assign per_set = tap_q & ~tap_now;   // one event per period, on the falling tap [RL13]

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tap_q      <= 1'b0;
      wave_out_q <= 1'b0;
    end else begin
      tap_q      <= tap_now;
      wave_out_q <= tap_now & wave_out_en_q;   // [RL11] [RL21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags: a set in the clearing cycle wins over the read clear
  logic al_set, flag_clr, per_d, al_d, upd_d, req_now, irq_level;
  assign al_set   = upd_end_q
                  & al_match(buf_q[rtc_pkg::ADDR_AL_SEC[3:0]], to_ext({1'b0, sec_q}, fmt_bin))
                  & al_match(buf_q[rtc_pkg::ADDR_AL_MIN[3:0]], to_ext({1'b0, min_q}, fmt_bin))
                  & al_match(buf_q[rtc_pkg::ADDR_AL_HR[3:0]], hour_ext(hour_q, fmt_bin, h24));  // [RL17]
  assign flag_clr = rd_done & (addr_q == rtc_pkg::ADDR_FLAGS);   // [RL16]
  assign per_d    = (periodic_flag_q & ~flag_clr) | per_set;     // [RL14]
  assign al_d     = (alarm_flag_q & ~flag_clr) | al_set;
  assign upd_d    = (update_done_flag_q & ~flag_clr) | upd_end_q;   // [RL4]
  assign req_now  = (per_set & periodic_irq_en_q) | (al_set & alarm_irq_en_q)
                  | (upd_end_q & update_irq_en_q & ~transfer_freeze_q);   // [RL14] [RL19]
  assign irq_level = (per_d & periodic_irq_en_q) | (al_d & alarm_irq_en_q)
                   | (upd_d & update_irq_en_q & ~transfer_freeze_q);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      periodic_flag_q    <= 1'b0;
      alarm_flag_q       <= 1'b0;
      update_done_flag_q <= 1'b0;
      irq_summary_flag_q <= 1'b0;
      irq_pin_oe_q       <= 1'b0;
    end else begin
      periodic_flag_q    <= per_d;
      alarm_flag_q       <= al_d;
      update_done_flag_q <= upd_d;
      irq_summary_flag_q <= (irq_summary_flag_q & ~flag_clr) | req_now;   // [RL15]
      irq_pin_oe_q       <= irq_level;   // [RL20]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: drive the pins only while selected and strobed
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    if (addr_q < 8'(rtc_pkg::NUM_TIME)) rd_data = buf_q[addr_q[3:0]];   // [RL25]
    else if (addr_q == rtc_pkg::ADDR_CTRL_A)
      rd_data = {update_pending_q & ~transfer_freeze_q, osc_ctrl_q, rate_select_q};  // [RL23]
    else if (addr_q == rtc_pkg::ADDR_CTRL_B)
      rd_data = {transfer_freeze_q, periodic_irq_en_q, alarm_irq_en_q, update_irq_en_q,
                 wave_out_en_q, data_format_sel_q, hour_format_sel_q, season_adj_en_q};
    else if (addr_q == rtc_pkg::ADDR_FLAGS)
      rd_data = {irq_summary_flag_q, periodic_flag_q, alarm_flag_q, update_done_flag_q, 4'h0};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ad_out_q <= 8'h00;
      ad_oe_q  <= 1'b0;
    end else begin
      ad_out_q <= rd_data;
      ad_oe_q  <= rd_active;
    end
  end

  assign ad_out      = ad_out_q;
  assign ad_oe       = ad_oe_q;
  assign irq_pin_out = 1'b0;   // open drain: only ever pulls low
  assign irq_pin_oe  = irq_pin_oe_q;
  assign wave_out    = wave_out_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_update;
    upd_tick ##1 upd_end_q;
  endsequence

  property p_update_end;
    s_update |=> !update_pending_q && update_done_flag_q;
  endproperty
  a_update_end: assert property (p_update_end) else $error("update end wrong");  // [RL4]

  property p_pending_lead;
    upd_tick |-> update_pending_q;
  endproperty
  a_pending_lead: assert property (p_pending_lead) else $error("pending not set");  // [RL3]

  property p_freeze_hold;
    upd_end_q && transfer_freeze_q && !wr_done |=> $stable(buf_q[0]);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("frozen buffer moved");  // [RL2]

  property p_sec_step;
    upd_tick && !wr_done && sec_q != 6'd59 |=> sec_q == 6'($past(sec_q) + 6'd1);
  endproperty
  a_sec_step: assert property (p_sec_step) else $error("seconds not advanced");  // [RL1]

  property p_wave_low;
    !wave_out_en_q [*2] |-> !wave_out;
  endproperty
  a_wave_low: assert property (p_wave_low) else $error("wave while disabled");  // [RL21]

  property p_read_clear;
    flag_clr && !per_set && !upd_end_q |=> !irq_summary_flag_q && !alarm_flag_q ##1 !irq_pin_oe;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag read not cleared");  // [RL16]

  property p_upd_irq;
    s_update ##0 (update_irq_en_q && !transfer_freeze_q) |=> irq_summary_flag_q ##1 irq_pin_oe;
  endproperty
  a_upd_irq: assert property (p_upd_irq) else $error("update request missing");  // [RL19]

  property p_alarm_any;
    s_update ##0 (buf_q[1][7:6] == 2'b11 && buf_q[3][7:6] == 2'b11 && buf_q[5][7:6] == 2'b11)
      |=> alarm_flag_q;
  endproperty
  a_alarm_any: assert property (p_alarm_any) else $error("don't-care alarm missed");  // [RL18]

  property p_hold_div;
    div_hold |=> div_q == rtc_pkg::DIV_HALF && !upd_tick;
  endproperty
  a_hold_div: assert property (p_hold_div) else $error("divider not held");  // [RL22]

  property p_hour_range;
    hour_q <= 5'd23 && sec_q <= 6'd59;
  endproperty
  a_hour_range: assert property (p_hour_range) else $error("time out of range");  // [RL6]

endmodule

// *** dv/rtc_host_model.sv ***
/* host side of the multiplexed address/data bus, with write and read tasks.
   assumes the bench calls the tasks; bus level resolved from the core enable. */
`timescale 1ns/10ps
module rtc_host_model (
  input  wire logic       ref_clk,     // core clock
  input  wire logic [7:0] ad_out,      // core read data
  input  wire logic       ad_oe,       // core drives the bus
  output logic      [7:0] ad_in,       // resolved bus level
  output logic            addr_strobe, // address latch
  output logic            rd_strobe_n, // read strobe
  output logic            wr_strobe_n, // write strobe
  output logic            chip_sel_n   // chip select
);
  logic [7:0] drv_q;                   // host side of the bus
  // released bus shows the inverse of the last value, so no stale match
  assign ad_in = ad_oe ? ad_out : drv_q;
  initial begin
    {addr_strobe, rd_strobe_n, wr_strobe_n, chip_sel_n} = 4'h7;
    drv_q = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // six-cycle phases stay clear of the four-cycle minimum
  task automatic adr(input logic [7:0] a);
    chip_sel_n = 1'b0;
    drv_q = a;
    addr_strobe = 1'b1;
    step(6);
    addr_strobe = 1'b0;
    step(6);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    adr(a);
    drv_q = d;
    wr_strobe_n = 1'b0;
    step(6);
    wr_strobe_n = 1'b1;
    step(6);
    drv_q = ~d;
    chip_sel_n = 1'b1;
    step(2);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    adr(a);
    drv_q = ~a;
    rd_strobe_n = 1'b0;
    step(6);
    // undriven bus reads as unknown, so a missing enable cannot pass
    d = ad_oe ? ad_out : 8'hXX;
    rd_strobe_n = 1'b1;
    step(6);
    chip_sel_n = 1'b1;
    step(2);
  endtask
endmodule

// *** dv/tb.sv ***
/* bench: register, square-wave and periodic-event tests of the clock core.
   assumes the package, the core and the host model compile first. */
`timescale 1ns/10ps
module tb;
  logic       ref_clk, nrst, ad_oe, as, rd_n, wr_n, cs_n, irq_oe, wave, wave_q, irq_o;
  logic       wave_hi = 1'b0;
  logic [7:0] ad_in, ad_out, rd_v;
  int         err_count = 0, samples_checked = 0, cyc = 0, last_e = 0, half_p = 0;
  // time and alarm bytes, valid in BCD
  logic [7:0] tbl [10] = '{8'h45, 8'hC5, 8'h30, 8'hC0, 8'h11, 8'hC0, 8'h03, 8'h28,
                           8'h02, 8'h24};
  rtc_core dut_u (.ref_clk(ref_clk), .nrst(nrst), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .addr_strobe(as), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
    .chip_sel_n(cs_n), .irq_pin_out(irq_o), .irq_pin_oe(irq_oe), .wave_out(wave));
  rtc_host_model host_u (.ref_clk(ref_clk), .ad_out(ad_out), .ad_oe(ad_oe),
    .ad_in(ad_in), .addr_strobe(as), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
    .chip_sel_n(cs_n));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("mismatches %0d of %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, rd_v);
    chk(rd_v, exp);
  endtask
  // cycle ceiling and square-wave edge spacing
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    wave_q <= wave;
    if (wave === 1'b1) wave_hi <= 1'b1;
    if (wave !== wave_q) begin
      half_p <= cyc - last_e;
      last_e <= cyc;
    end
    if (cyc == 100000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    nrst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 nrst = 1'b1;
    host_u.step(3);
    rc(8'h0B, 8'h00);
    rc(8'h0C, 8'h00);
    host_u.wr(8'h0B, 8'h80);
    for (int i = 0; i < 10; i++) host_u.wr(i[7:0], tbl[i]);
    for (int i = 0; i < 10; i++) rc(i[7:0], tbl[i]);
    // frozen writes must reach the counting copy as plain values
    chk(dut_u.sec_q, 16'h002D);
    chk(dut_u.hour_q, 16'h000B);
    host_u.wr(8'h0B, 8'h86);
    host_u.wr(8'h04, 8'h17);
    chk(dut_u.hour_q, 16'h0017);
    rc(8'h04, 8'h17);
    host_u.wr(8'h0B, 8'h80);
    host_u.wr(8'h04, 8'h92);
    chk(dut_u.hour_q, 16'h000C);
    host_u.wr(8'h0E, 8'h5A);
    rc(8'h0E, 8'h00);
    host_u.wr(8'h0A, 8'hE3);
    rc(8'h0A, 8'h63);
    host_u.wr(8'h0A, 8'h23);
    rc(8'h0A, 8'h23);
    // wave and periodic request disabled for over one rate-3 period
    host_u.step(32000);
    chk(wave_hi, 1'b0);
    chk(irq_oe, 1'b0);
    chk(irq_o, 1'b0);
    rc(8'h0C, 8'h40);
    host_u.wr(8'h0B, 8'hC8);
    for (int i = 0; i < 32000 && irq_oe !== 1'b1; i++) host_u.step(1);
    chk(irq_oe, 1'b1);
    rc(8'h0C, 8'hC0);
    chk(irq_oe, 1'b0);
    rc(8'h0C, 8'h00);
    host_u.step(16000);
    // half period of 8192 Hz, allowing a few cycles of time-base jitter
    chk(half_p >= rtc_pkg::CLK_HZ / 16384 && half_p < rtc_pkg::CLK_HZ / 16384 + 3, 1'b1);
    chk(wave_hi, 1'b1);
    conclude();
  end
endmodule
